// File: hw/cos_regs.svh
// register offsets, reset values, timing counts and dictionary index ranges
`ifndef COS_REGS_SVH
`define COS_REGS_SVH
`define COS_CTRL_OFF 12'h000
`define COS_STAT_OFF 12'h004
`define COS_RED_OFF 12'h008
`define COS_TCFG_OFF 12'h00C
`define COS_TTIM_OFF 12'h010
`define COS_SWL_OFF 12'h014
`define COS_ODADR_OFF 12'h018
`define COS_ODDAT_OFF 12'h01C
`define COS_CTRL_RST 32'h0000_0000
`define COS_RED_RST 32'h0000_0303
`define COS_TCFG_RST 32'h0000_0001
`define COS_SWL_RST 32'h0000_03E8
`define COS_MS_NS 1000000
`define COS_CLK_NS 4
`define COS_MS_CYC (`COS_MS_NS / `COS_CLK_NS)
`define COS_OD_DEV 16'h2000
`define COS_OD_RW 16'h6000
`define COS_OD_RO 16'h7000
`define COS_OD_END 16'h8000
`define COS_OD_WORDS 64
`endif

// File: hw/cos_pkg.sv
// types of the node protocol block
package cos_pkg;
  typedef enum logic [4:0] {
    COS_INIT = 5'h01,
    COS_PREOP = 5'h02,
    COS_OPER = 5'h04,
    COS_STOP = 5'h08,
    COS_RSTCOM = 5'h10
  } cos_state_t;
  typedef enum logic [2:0] {
    COS_CMD_START = 3'h1,
    COS_CMD_STOP = 3'h2,
    COS_CMD_PREOP = 3'h3,
    COS_CMD_RSTAPP = 3'h4,
    COS_CMD_RSTCOM = 3'h5
  } cos_cmd_t;
endpackage

// File: hw/cos_node.sv
// network state, heartbeat redundancy, PDO timing and SDO dictionary
`timescale 1ns/10ps
`include "cos_regs.svh"
module cos_node (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // decoded network events
  input wire logic NMT_VALID,
  input wire logic [2:0] NMT_CMD,
  input wire logic SYNC_RX,
  input wire logic MASTER_HB_RX,
  input wire logic RPDO_RX,
  input wire logic RPDO_SYNC,
  input wire logic TPDO_TRIG,
  // sdo requests
  input wire logic SDO_VALID,
  input wire logic SDO_WRITE,
  input wire logic [15:0] SDO_INDEX,
  input wire logic [7:0] SDO_SUB,
  input wire logic [1:0] SDO_SIZE,
  input wire logic [31:0] SDO_WDATA,
  // node outputs
  output logic BOOTUP_TX,
  output logic HB_TX,
  output logic HB_EVENT,
  output logic BUS_SEL,
  output logic TPDO_SYNC_TX,
  output logic TPDO_ASYNC_TX,
  output logic RPDO_PROC,
  output logic SYNC_ERR,
  output logic SDO_ACK,
  output logic SDO_ABORT,
  output logic [31:0] SDO_RDATA
);
  cos_pkg::cos_state_t state;
  cos_pkg::cos_state_t next_state;
  logic [31:0] ctrl, red, tcfg, ttim, swl, odadr;
  logic [31:0] od_mem [0:`COS_OD_WORDS-1];
  logic [17:0] ms_cnt;
  logic [15:0] hb_ms, mhb_ms;
  logic [7:0] ev_cnt, tog_cnt, sync_cnt;
  logic [15:0] evt_ms, inh_ms;
  logic [31:0] win_cnt;
  logic [7:0] rq_cnt, rq_run;
  logic win_open, trig_pend;

  function automatic logic od_ok(input logic [15:0] idx);
    od_ok = idx >= `COS_OD_DEV && idx < `COS_OD_END;
  endfunction

  // ctrl: 0 auto-start, 1 window check, 2 sync tpdo; red: 7:0 events
  // per switch, 15:8 max toggles; tcfg: 7:0 sync period; ttim: 15:0
  // event ms, 31:16 inhibit ms; swl 15:0 in cycles
  wire ms_tick = ms_cnt == 18'(`COS_MS_CYC - 1);
  wire auto_start = ctrl[0];
  wire swl_chk = ctrl[1];
  wire sync_mode = ctrl[2];
  wire [7:0] ev_per_sw = red[7:0];
  wire [7:0] tog_max = red[15:8];
  wire red_done = tog_cnt >= tog_max;
  wire oper = state == cos_pkg::COS_OPER;
  wire sw_now = HB_EVENT && !red_done && ev_cnt + 8'h1 >= ev_per_sw;
  wire sync_due = oper && sync_mode && SYNC_RX &&
                  sync_cnt + 8'h1 >= tcfg[7:0];
  wire evt_en = ttim[15:0] != 16'h0;
  wire inh_ok = inh_ms == 16'h0;
  wire evt_exp = evt_en && ms_tick && evt_ms == 16'h1;
  wire async_go = oper && !sync_mode && inh_ok &&
                  (trig_pend || TPDO_TRIG || evt_exp);
  // upper half of swl is the master heartbeat timeout, not window length
  wire win_end = win_open && win_cnt + 32'h1 >= {16'h0, swl[15:0]};
  wire rq_new = RPDO_RX && RPDO_SYNC;
  wire rpdo_now = RPDO_RX && !RPDO_SYNC;
  wire rq_drain = rq_run != 8'h0 && !rpdo_now;
  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire [5:0] od_word = odadr[5:0];
  wire [5:0] sdo_slot = {SDO_INDEX[12] , SDO_SUB[4:0]};
  wire sdo_legal = od_ok(SDO_INDEX) && SDO_SIZE != 2'h3;
  wire sdo_ro = SDO_INDEX >= `COS_OD_RO || SDO_INDEX < `COS_OD_RW ||
                SDO_SUB == 8'h0;
  wire sdo_fault = !sdo_legal || (SDO_WRITE && sdo_ro);

  always_comb begin
    next_state = state;
    if (state == cos_pkg::COS_INIT || state == cos_pkg::COS_RSTCOM) begin
      next_state = auto_start ? cos_pkg::COS_OPER : cos_pkg::COS_PREOP;
    end else if (NMT_VALID) begin
      unique case (NMT_CMD)
        cos_pkg::COS_CMD_START: next_state = cos_pkg::COS_OPER;
        cos_pkg::COS_CMD_STOP: next_state = cos_pkg::COS_STOP;
        cos_pkg::COS_CMD_PREOP: next_state = cos_pkg::COS_PREOP;
        cos_pkg::COS_CMD_RSTAPP: next_state = cos_pkg::COS_INIT;
        cos_pkg::COS_CMD_RSTCOM: next_state = cos_pkg::COS_RSTCOM;
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= cos_pkg::COS_INIT;
      BOOTUP_TX <= 1'b0;
    end else begin
      state <= next_state;
      // boot-up only once initialization hands over
      BOOTUP_TX <= (state == cos_pkg::COS_INIT ||
                    state == cos_pkg::COS_RSTCOM) &&
                   next_state != state;
    end
  end

  // neither application reset nor comms reset clears the dictionary; reset never touches it
  always_ff @(posedge MCLK) begin
    if (SDO_VALID && !sdo_fault && SDO_WRITE) begin
      od_mem[sdo_slot] <= SDO_WDATA;
    end else if (apb_wr && PADDR == `COS_ODDAT_OFF) begin
      od_mem[od_word] <= PWDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SDO_ACK <= 1'b0;
      SDO_ABORT <= 1'b0;
      SDO_RDATA <= 32'h0;
    end else begin
      SDO_ACK <= SDO_VALID && !sdo_fault;
      SDO_ABORT <= SDO_VALID && sdo_fault;
      SDO_RDATA <= SDO_VALID && !SDO_WRITE && !sdo_fault ?
                   od_mem[sdo_slot] & (SDO_SIZE == 2'h0 ? 32'hFF :
                   SDO_SIZE == 2'h1 ? 32'hFFFF : 32'hFFFF_FFFF) :
                   32'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ms_cnt <= 18'h0;
      hb_ms <= 16'h0;
      mhb_ms <= 16'h0;
      HB_TX <= 1'b0;
      HB_EVENT <= 1'b0;
    end else begin
      ms_cnt <= ms_tick ? 18'h0 : ms_cnt + 18'h1;
      // producer period in ms minus one, shared with the tpdo inhibit time in ttim 31:16
      hb_ms <= ms_tick ? (hb_ms == ttim[31:16] ? 16'h0 : hb_ms + 16'h1)
                       : hb_ms;
      HB_TX <= ms_tick && hb_ms == ttim[31:16] &&
               state != cos_pkg::COS_INIT;
      if (MASTER_HB_RX || HB_EVENT) begin
        mhb_ms <= 16'h0;
      end else if (ms_tick) begin
        mhb_ms <= mhb_ms + 16'h1;
      end
      HB_EVENT <= !HB_EVENT && !MASTER_HB_RX && ms_tick &&
                  mhb_ms + 16'h1 >= swl[31:16] && swl[31:16] != 16'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ev_cnt <= 8'h0;
      tog_cnt <= 8'h0;
      BUS_SEL <= 1'b0;
    end else if (HB_EVENT && !red_done) begin
      ev_cnt <= sw_now ? 8'h0 : ev_cnt + 8'h1;
      if (sw_now) begin
        BUS_SEL <= !BUS_SEL;
        tog_cnt <= tog_cnt + 8'h1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync_cnt <= 8'h0;
      TPDO_SYNC_TX <= 1'b0;
      win_open <= 1'b0;
      win_cnt <= 32'h0;
      SYNC_ERR <= 1'b0;
      rq_cnt <= 8'h0;
      rq_run <= 8'h0;
      RPDO_PROC <= 1'b0;
    end else begin
      if (SYNC_RX) begin
        sync_cnt <= sync_due ? 8'h0 : sync_cnt + 8'h1;
      end
      TPDO_SYNC_TX <= sync_due;
      win_open <= SYNC_RX ? 1'b1 : (win_end ? 1'b0 : win_open);
      win_cnt <= SYNC_RX ? 32'h0 : win_cnt + 32'h1;
      // one released frame drained per cycle; an async frame goes first
      RPDO_PROC <= rpdo_now || rq_drain;
      // frames queued in this window wait for the next sync
      if (SYNC_RX) begin
        rq_cnt <= {7'h0, rq_new};
        rq_run <= rq_run + rq_cnt - {7'h0, rq_drain};
      end else begin
        rq_cnt <= rq_cnt + {7'h0, rq_new};
        rq_run <= rq_run - {7'h0, rq_drain};
      end
      SYNC_ERR <= win_end && swl_chk && rq_run != 8'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      evt_ms <= 16'h0;
      inh_ms <= 16'h0;
      trig_pend <= 1'b0;
      TPDO_ASYNC_TX <= 1'b0;
    end else begin
      trig_pend <= (trig_pend || TPDO_TRIG) && !async_go;
      TPDO_ASYNC_TX <= async_go;
      if (async_go) begin
        inh_ms <= ttim[31:16];
        evt_ms <= ttim[15:0];
      end else if (ms_tick) begin
        inh_ms <= inh_ok ? 16'h0 : inh_ms - 16'h1;
        evt_ms <= evt_ms <= 16'h1 ? ttim[15:0] : evt_ms - 16'h1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl <= `COS_CTRL_RST;
      red <= `COS_RED_RST;
      tcfg <= `COS_TCFG_RST;
      ttim <= 32'h0;
      swl <= `COS_SWL_RST;
      odadr <= 32'h0;
    end else if (apb_wr) begin
      if (PADDR == `COS_CTRL_OFF) ctrl <= PWDATA;
      if (PADDR == `COS_RED_OFF) red <= PWDATA;
      if (PADDR == `COS_TCFG_OFF) tcfg <= PWDATA;
      if (PADDR == `COS_TTIM_OFF) ttim <= PWDATA;
      if (PADDR == `COS_SWL_OFF) swl <= PWDATA;
      if (PADDR == `COS_ODADR_OFF) odadr <= PWDATA;
    end
  end

  wire [31:0] stat = {8'h0, tog_cnt, ev_cnt, 1'b0, red_done, BUS_SEL,
                      state};
  always_comb begin
    PREADY = 1'b1;
    PSLVERR = 1'b0;
    unique case (PADDR)
      `COS_CTRL_OFF: PRDATA = ctrl;
      `COS_STAT_OFF: PRDATA = stat;
      `COS_RED_OFF: PRDATA = red;
      `COS_TCFG_OFF: PRDATA = tcfg;
      `COS_TTIM_OFF: PRDATA = ttim;
      `COS_SWL_OFF: PRDATA = swl;
      `COS_ODADR_OFF: PRDATA = odadr;
      `COS_ODDAT_OFF: PRDATA = od_mem[od_word];
      default: begin
        PRDATA = 32'h0;
        PSLVERR = PSEL && PENABLE;
      end
    endcase
  end

  property p_boot;
    @(posedge MCLK) disable iff (!RST_N)
    BOOTUP_TX |-> $past(state) != state;
  endproperty
  a_boot: assert property (p_boot) else $error("boot without init end");

  property p_start;
    @(posedge MCLK) disable iff (!RST_N)
    (NMT_VALID && NMT_CMD == 3'h1 && state == cos_pkg::COS_PREOP)
      |=> state == cos_pkg::COS_OPER;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge MCLK) disable iff (!RST_N)
    (NMT_VALID && NMT_CMD == 3'h2 && state == cos_pkg::COS_OPER)
      |=> state == cos_pkg::COS_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_rst;
    @(posedge MCLK) disable iff (!RST_N)
    (NMT_VALID && NMT_CMD == 3'h5 && state == cos_pkg::COS_OPER)
      |=> state == cos_pkg::COS_RSTCOM ##1 BOOTUP_TX;
  endproperty
  a_rst: assert property (p_rst) else $error("reset comm wrong");

  property p_sw;
    @(posedge MCLK) disable iff (!RST_N)
    $changed(BUS_SEL) |-> $past(HB_EVENT) && !$past(red_done);
  endproperty
  a_sw: assert property (p_sw) else $error("bus switch without cause");

  property p_hold;
    @(posedge MCLK) disable iff (!RST_N)
    red_done |=> $stable(BUS_SEL);
  endproperty
  a_hold: assert property (p_hold) else $error("switched after limit");

  property p_sync;
    @(posedge MCLK) disable iff (!RST_N)
    TPDO_SYNC_TX |-> $past(SYNC_RX) && $past(oper);
  endproperty
  a_sync: assert property (p_sync) else $error("sync tpdo w/o sync");

  property p_inh;
    @(posedge MCLK) disable iff (!RST_N)
    TPDO_ASYNC_TX && ttim[31:16] != 16'h0 |=> !TPDO_ASYNC_TX [*8];
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit violated");

  property p_arpdo;
    @(posedge MCLK) disable iff (!RST_N)
    RPDO_RX && !RPDO_SYNC |=> RPDO_PROC;
  endproperty
  a_arpdo: assert property (p_arpdo) else $error("async rpdo late");

  c_boot: cover property (@(posedge MCLK) BOOTUP_TX);
  c_sw: cover property (@(posedge MCLK) $changed(BUS_SEL));
  c_async: cover property (@(posedge MCLK) TPDO_ASYNC_TX);
  c_err: cover property (@(posedge MCLK) SYNC_ERR);
endmodule

// File: sim/cos_master.sv
// behavioural network master driving nmt, sync, heartbeat and rpdo events
`timescale 1ns/10ps
module cos_master (
  // clock
  input wire logic MCLK,
  // events toward the node
  output logic NMT_VALID,
  output logic [2:0] NMT_CMD,
  output logic SYNC_RX,
  output logic MASTER_HB_RX,
  output logic RPDO_RX,
  output logic RPDO_SYNC
);
  initial begin
    {NMT_VALID, NMT_CMD, SYNC_RX, MASTER_HB_RX, RPDO_RX, RPDO_SYNC} = '0;
  end
  // codes idle inverted after each event so a stale code is never mistaken for valid
  task automatic nmt(input cos_pkg::cos_cmd_t c);
    NMT_VALID <= 1'b1;
    NMT_CMD <= c;
    @(posedge MCLK);
    NMT_VALID <= 1'b0;
    NMT_CMD <= ~c;
    @(posedge MCLK);
  endtask
  task automatic sync_ev;
    SYNC_RX <= 1'b1;
    @(posedge MCLK);
    SYNC_RX <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic hb;
    MASTER_HB_RX <= 1'b1;
    @(posedge MCLK);
    MASTER_HB_RX <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rpdo(input logic s);
    RPDO_RX <= 1'b1;
    RPDO_SYNC <= s;
    @(posedge MCLK);
    RPDO_RX <= 1'b0;
    RPDO_SYNC <= ~s;
    @(posedge MCLK);
  endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the node protocol block
`timescale 1ns/10ps
`include "cos_regs.svh"
module testbench;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic TPDO_TRIG = 1'b0;
  logic SDO_VALID = 1'b0;
  logic SDO_WRITE = 1'b0;
  logic [15:0] SDO_INDEX = 16'h0;
  logic [7:0] SDO_SUB = 8'h0;
  logic [1:0] SDO_SIZE = 2'h0;
  logic [31:0] SDO_WDATA = 32'h0;
  logic NMT_VALID, SYNC_RX, MASTER_HB_RX, RPDO_RX, RPDO_SYNC;
  logic [2:0] NMT_CMD;
  logic [31:0] PRDATA, SDO_RDATA, rd;
  logic PREADY, PSLVERR, BOOTUP_TX, HB_TX, HB_EVENT, BUS_SEL, TPDO_SYNC_TX;
  logic TPDO_ASYNC_TX, RPDO_PROC, SYNC_ERR, SDO_ACK, SDO_ABORT, err;
  int error_cnt = 0;
  int compares = 0;
  int n_boot = 0, n_ts = 0, n_ta = 0, n_rp = 0, n_se = 0, n_hb = 0;
  always #2 MCLK = ~MCLK;
  // pulses last one cycle, so tally them at every edge
  always @(posedge MCLK) begin
    n_boot += int'(BOOTUP_TX === 1'b1);
    n_ts += int'(TPDO_SYNC_TX === 1'b1);
    n_ta += int'(TPDO_ASYNC_TX === 1'b1);
    n_rp += int'(RPDO_PROC === 1'b1);
    n_se += int'(SYNC_ERR === 1'b1);
    n_hb += int'(HB_TX === 1'b1 || HB_EVENT === 1'b1);
  end
  cos_master m (.MCLK(MCLK), .NMT_VALID(NMT_VALID), .NMT_CMD(NMT_CMD),
    .SYNC_RX(SYNC_RX), .MASTER_HB_RX(MASTER_HB_RX), .RPDO_RX(RPDO_RX),
    .RPDO_SYNC(RPDO_SYNC));
  cos_node DUT (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NMT_VALID(NMT_VALID),
    .NMT_CMD(NMT_CMD), .SYNC_RX(SYNC_RX), .MASTER_HB_RX(MASTER_HB_RX),
    .RPDO_RX(RPDO_RX), .RPDO_SYNC(RPDO_SYNC), .TPDO_TRIG(TPDO_TRIG),
    .SDO_VALID(SDO_VALID), .SDO_WRITE(SDO_WRITE), .SDO_INDEX(SDO_INDEX),
    .SDO_SUB(SDO_SUB), .SDO_SIZE(SDO_SIZE), .SDO_WDATA(SDO_WDATA),
    .BOOTUP_TX(BOOTUP_TX), .HB_TX(HB_TX), .HB_EVENT(HB_EVENT),
    .BUS_SEL(BUS_SEL), .TPDO_SYNC_TX(TPDO_SYNC_TX),
    .TPDO_ASYNC_TX(TPDO_ASYNC_TX), .RPDO_PROC(RPDO_PROC),
    .SYNC_ERR(SYNC_ERR), .SDO_ACK(SDO_ACK), .SDO_ABORT(SDO_ABORT),
    .SDO_RDATA(SDO_RDATA));
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic state_is(input cos_pkg::cos_state_t s);
    apb(1'b0, `COS_STAT_OFF, 32'h0);
    chk({27'h0, rd[4:0]}, {27'h0, s});
  endtask
  task automatic sdo(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [1:0] z, input logic [31:0] d, input logic ok,
    input logic [31:0] exp);
    SDO_VALID <= 1'b1;
    SDO_WRITE <= w;
    SDO_INDEX <= i;
    SDO_SUB <= s;
    SDO_SIZE <= z;
    SDO_WDATA <= d;
    @(posedge MCLK);
    SDO_VALID <= 1'b0;
    @(posedge MCLK);
    chk({30'h0, SDO_ACK, SDO_ABORT}, {30'h0, ok, ~ok});
    if (!w && ok)
      chk(SDO_RDATA, exp);
  endtask
  task automatic t_boot;
    repeat (4) @(posedge MCLK);
    chk(n_boot, 1);
    state_is(cos_pkg::COS_PREOP);
    apb(1'b0, `COS_RED_OFF, 32'h0);
    chk(rd, `COS_RED_RST);
    apb(1'b0, `COS_SWL_OFF, 32'h0);
    chk(rd, `COS_SWL_RST);
    apb(1'b0, `COS_TCFG_OFF, 32'h0);
    chk(rd, `COS_TCFG_RST);
  endtask
  task automatic t_nmt;
    cos_pkg::cos_cmd_t c[4] = '{cos_pkg::COS_CMD_START, cos_pkg::COS_CMD_STOP,
      cos_pkg::COS_CMD_PREOP, cos_pkg::COS_CMD_START};
    cos_pkg::cos_state_t s[4] = '{cos_pkg::COS_OPER, cos_pkg::COS_STOP,
      cos_pkg::COS_PREOP, cos_pkg::COS_OPER};
    for (int k = 0; k < 4; k++) begin
      m.nmt(c[k]);
      state_is(s[k]);
    end
  endtask
  task automatic t_resets;
    cos_pkg::cos_cmd_t c[2] = '{cos_pkg::COS_CMD_RSTCOM,
      cos_pkg::COS_CMD_RSTAPP};
    int b;
    for (int k = 0; k < 2; k++) begin
      b = n_boot;
      m.nmt(c[k]);
      repeat (4) @(posedge MCLK);
      chk(n_boot, b + 1);
      state_is(cos_pkg::COS_PREOP);
    end
  endtask
  task automatic t_autostart;
    apb(1'b1, `COS_CTRL_OFF, 32'h1);
    m.nmt(cos_pkg::COS_CMD_RSTCOM);
    repeat (4) @(posedge MCLK);
    state_is(cos_pkg::COS_OPER);
  endtask
  task automatic t_sync_tpdo;
    apb(1'b1, `COS_TCFG_OFF, 32'h3);
    apb(1'b1, `COS_CTRL_OFF, 32'h4);
    n_ts = 0;
    repeat (6) m.sync_ev;
    repeat (3) @(posedge MCLK);
    chk(n_ts, 2);
  endtask
  task automatic t_rpdo;
    n_rp = 0;
    m.hb;
    m.rpdo(1'b0);
    repeat (2) @(posedge MCLK);
    chk(n_rp, 1);
    m.rpdo(1'b1);
    repeat (4) @(posedge MCLK);
    chk(n_rp, 1);
    m.sync_ev;
    repeat (2) @(posedge MCLK);
    chk(n_rp, 2);
  endtask
  task automatic t_swl;
    int r;
    apb(1'b1, `COS_SWL_OFF, 32'h4);
    apb(1'b1, `COS_CTRL_OFF, 32'h6);
    n_se = 0;
    r = n_rp;
    repeat (2) m.rpdo(1'b1);
    m.sync_ev;
    repeat (8) @(posedge MCLK);
    chk(n_se, 0);
    chk(n_rp, r + 2);
    // six frames cannot drain inside a four cycle window
    repeat (6) m.rpdo(1'b1);
    chk(n_rp, r + 2);
    m.sync_ev;
    repeat (8) @(posedge MCLK);
    chk(n_se, 1);
    chk(n_rp, r + 8);
  endtask
  task automatic t_quiet;
    // the whole run is shorter than one millisecond tick
    chk(n_hb, 0);
    chk({31'h0, BUS_SEL}, 32'h0);
  endtask
  task automatic t_trig;
    apb(1'b1, `COS_CTRL_OFF, 32'h0);
    apb(1'b1, `COS_TTIM_OFF, 32'h0);
    n_ta = 0;
    TPDO_TRIG <= 1'b1;
    @(posedge MCLK);
    TPDO_TRIG <= 1'b0;
    repeat (4) @(posedge MCLK);
    chk(n_ta, 1);
  endtask
  task automatic t_sdo;
    sdo(1, 16'h6000, 8'h01, 2'h2, 32'hDEADBEEF, 1, 32'h0);
    sdo(0, 16'h6000, 8'h01, 2'h2, 32'h0, 1, 32'hDEADBEEF);
    sdo(0, 16'h6000, 8'h01, 2'h0, 32'h0, 1, 32'h000000EF);
    sdo(0, 16'h6000, 8'h01, 2'h1, 32'h0, 1, 32'h0000BEEF);
    sdo(0, 16'h6000, 8'h01, 2'h3, 32'h0, 0, 32'h0);
    sdo(1, 16'h7000, 8'h01, 2'h2, 32'h1, 0, 32'h0);
    sdo(1, 16'h6000, 8'h00, 2'h0, 32'h1, 0, 32'h0);
    sdo(0, 16'h1000, 8'h00, 2'h2, 32'h0, 0, 32'h0);
    apb(1'b1, `COS_ODADR_OFF, 32'h1);
    apb(1'b0, `COS_ODDAT_OFF, 32'h0);
    chk(rd, 32'hDEADBEEF);
    apb(1'b1, `COS_ODDAT_OFF, 32'h0BAD_F00D);
    sdo(0, 16'h6000, 8'h01, 2'h2, 32'h0, 1, 32'h0BAD_F00D);
  endtask
  task automatic t_apb;
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    t_boot;
    t_nmt;
    t_resets;
    t_autostart;
    t_sync_tpdo;
    t_rpdo;
    t_swl;
    t_trig;
    t_sdo;
    t_apb;
    t_quiet;
    wrap_up;
  end
  // whole run needs a few hundred cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge MCLK);
    error_cnt++;
    wrap_up;
  end
endmodule
